// ===== clock_fault_monitors.sv
// The APB slave port and the register addresses are this design's own decisions.
`timescale 1ns/10ps
module clock_fault_monitors
  import clock_fault_monitors_pkg::*;
#(
  parameter int SETTLE_CYCLES = HF_SETTLE_CYCLES
) (
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        rstn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  // supervised clocks, sampled levels
  input  wire logic        low_freq_clock,
  input  wire logic        mainClockActivity,
  input  wire logic        hf_crystal_osc,
  input  wire logic        hf_clock_input_pin,
  // operating mode
  input  wire logic        deep_standby_mode,
  input  wire logic        shutdownMode,
  // system outputs
  output logic             boot_reset,
  output logic             hfClockSelectOk,
  output logic             hfCrystalEnable,
  output logic             hfSourceSelect,
  output logic             irq
);

  // register state
  logic                main_clock_dead_check_en;
  logic [WINDOW_W-1:0] windowSetting;
  logic                hfSrcPin;
  logic                hf_clock_good_flag;
  logic                hf_clock_dead_flag;
  logic [IRQ_W-1:0]    intStatus;
  logic [IRQ_W-1:0]    intMask;

  // bus decode
  logic accessDone;
  logic wrDone;
  logic rdDone;
  logic mapped;
  logic [31:0] next_prdata;
  logic monActive;
  logic settleBusy;

  assign accessDone = psel & penable & pready;
  assign wrDone     = accessDone & pwrite;
  assign rdDone     = accessDone & ~pwrite;

  always_comb begin
    mapped = 1'b1;
    next_prdata = 32'h0000_0000;
    case (paddr)
      MAIN_CFG_OFFSET: begin
        next_prdata[DEAD_CHECK_BIT] = main_clock_dead_check_en;
        next_prdata[WINDOW_LSB +: WINDOW_W] = windowSetting;
      end
      HF_CTRL_OFFSET: begin
        next_prdata[HF_START_BIT] = hfCrystalEnable;
        next_prdata[HF_SRC_BIT]   = hfSrcPin;
      end
      CLK_STATUS_OFFSET: begin
        next_prdata[GOOD_BIT]       = hf_clock_good_flag;
        next_prdata[DEAD_BIT]       = hf_clock_dead_flag;
        next_prdata[MON_ACTIVE_BIT] = monActive;
        next_prdata[SETTLING_BIT]   = settleBusy;
      end
      INT_STATUS_OFFSET: next_prdata[IRQ_W-1:0] = intStatus;
      INT_MASK_OFFSET:   next_prdata[IRQ_W-1:0] = intMask;
      default:           mapped = 1'b0;
    endcase
  end

  // one wait state: data and error are registered on the same edge as pready
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel & penable & ~pready;
      if (psel & penable & ~pready) begin
        prdata  <= pwrite ? 32'h0000_0000 : next_prdata;
        pslverr <= ~mapped;
      end else begin
        pslverr <= 1'b0;
      end
    end
  end

  // main clock configuration
  logic [WINDOW_W-1:0] wrWindow;

  always_comb begin
    wrWindow = pwdata[WINDOW_LSB +: WINDOW_W];
    if (wrWindow < WINDOW_MIN) begin
      wrWindow = WINDOW_MIN;
    end else if (wrWindow > WINDOW_MAX) begin
      wrWindow = WINDOW_MAX;
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      main_clock_dead_check_en <= 1'b0;
      windowSetting            <= WINDOW_RESET;
    end else if (wrDone && paddr == MAIN_CFG_OFFSET) begin
      main_clock_dead_check_en <= pwdata[DEAD_CHECK_BIT];
      windowSetting            <= wrWindow;
    end
  end

  // main clock activity monitor
  logic                  lfRise;
  logic                  mainRise;
  logic [WINDOW_W-1:0]   idleCount;
  logic                  mainFault;
  logic [BOOT_CNT_W-1:0] bootCount;

  activity_edge lfEdge (
    .core_clk (core_clk),
    .rstn     (rstn),
    .sig      (low_freq_clock),
    .rise     (lfRise)
  );

  activity_edge mainEdge (
    .core_clk (core_clk),
    .rstn     (rstn),
    .sig      (mainClockActivity),
    .rise     (mainRise)
  );

  // relies on software enabling only once the slow clock runs
  assign monActive = main_clock_dead_check_en & ~deep_standby_mode & ~shutdownMode;
  assign mainFault = monActive & lfRise & ~mainRise & (idleCount == windowSetting - 1'b1);

  // counts slow-clock edges since the last main-clock edge
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      idleCount <= '0;
    end else if (!monActive || mainRise || mainFault || bootCount != '0) begin
      idleCount <= '0;
    end else if (lfRise) begin
      idleCount <= idleCount + 1'b1;
    end
  end

  // boot reset pulse, stretched so the reset tree sees it
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      bootCount  <= '0;
      boot_reset <= 1'b0;
    end else begin
      if (mainFault) begin
        bootCount  <= BOOT_CNT_W'(BOOT_RESET_CYCLES);
        boot_reset <= 1'b1;
      end else if (bootCount != '0) begin
        bootCount  <= bootCount - 1'b1;
        boot_reset <= (bootCount != BOOT_CNT_W'(1));
      end else begin
        boot_reset <= 1'b0;
      end
    end
  end

  // high-frequency start-up monitor
  logic startReq;
  logic settleDone;
  logic hfSampled;
  logic hfRise;
  logic [EDGE_CNT_W-1:0] edgeCount;
  logic activitySeen;

  // crystal start, or a change of source to the pin, begins an attempt
  assign startReq = wrDone && paddr == HF_CTRL_OFFSET &&
                    ((pwdata[HF_START_BIT] & ~pwdata[HF_SRC_BIT]) ||
                     (pwdata[HF_SRC_BIT] & ~hfSrcPin));

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      hfCrystalEnable <= 1'b0;
      hfSrcPin        <= 1'b0;
      hfSourceSelect  <= 1'b0;
    end else begin
      if (wrDone && paddr == HF_CTRL_OFFSET) begin
        hfCrystalEnable <= pwdata[HF_START_BIT];
        hfSrcPin        <= pwdata[HF_SRC_BIT];
      end
      hfSourceSelect <= hfSrcPin;
    end
  end

  assign hfSampled = hfSrcPin ? hf_clock_input_pin : hf_crystal_osc;

  activity_edge hfEdge (
    .core_clk (core_clk),
    .rstn     (rstn),
    .sig      (hfSampled),
    .rise     (hfRise)
  );

  settle_timer #(
    .WIDTH (SETTLE_W),
    .COUNT (SETTLE_CYCLES)
  ) hfSettle (
    .core_clk (core_clk),
    .rstn     (rstn),
    .start    (startReq),
    .busy     (settleBusy),
    .done     (settleDone)
  );

  // a stuck input gives no edges; a few edges avoid taking one glitch as life
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      edgeCount <= '0;
    end else if (startReq) begin
      edgeCount <= '0;
    end else if (settleBusy && hfRise && !activitySeen) begin
      edgeCount <= edgeCount + 1'b1;
    end
  end

  assign activitySeen = (edgeCount >= EDGE_CNT_W'(HF_MIN_EDGES));

  hf_state_e hfState;

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      hfState            <= HF_IDLE;
      hf_clock_good_flag <= 1'b0;
      hf_clock_dead_flag <= 1'b0;
    end else if (startReq) begin
      hfState            <= HF_SETTLE;
      hf_clock_good_flag <= 1'b0;
      hf_clock_dead_flag <= 1'b0;
    end else begin
      case (hfState)
        HF_SETTLE: begin
          if (settleDone) begin
            hfState            <= activitySeen ? HF_GOOD : HF_DEAD;
            hf_clock_good_flag <= activitySeen;
            hf_clock_dead_flag <= ~activitySeen;
          end
        end
        HF_IDLE, HF_GOOD, HF_DEAD: begin
          hfState <= hfState;
        end
        default: begin
          hfState <= HF_IDLE;
        end
      endcase
    end
  end

  // only a confirmed start lets the clock be selected
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      hfClockSelectOk <= 1'b0;
    end else begin
      hfClockSelectOk <= hf_clock_good_flag & ~startReq;
    end
  end

  // interrupts: sticky, cleared by reading, a new event wins over the clear
  logic [IRQ_W-1:0] events;
  logic [IRQ_W-1:0] next_intStatus;

  assign events[IRQ_GOOD_BIT]  = settleDone & activitySeen & (hfState == HF_SETTLE) & ~startReq;
  assign events[IRQ_DEAD_BIT]  = settleDone & ~activitySeen & (hfState == HF_SETTLE) & ~startReq;
  assign events[IRQ_FAULT_BIT] = mainFault;

  // irq follows the same next value, so a clear never hides a fresh event
  always_comb begin
    next_intStatus = intStatus | events;
    if (rdDone && paddr == INT_STATUS_OFFSET) begin
      next_intStatus = events;
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      intStatus <= '0;
    end else begin
      intStatus <= next_intStatus;
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      intMask <= '0;
    end else if (wrDone && paddr == INT_MASK_OFFSET) begin
      intMask <= pwdata[IRQ_W-1:0];
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(next_intStatus & intMask);
    end
  end

endmodule

// ===== clock_fault_monitors_pkg.sv
package clock_fault_monitors_pkg;

  // apb register byte offsets
  localparam logic [7:0] MAIN_CFG_OFFSET   = 8'h00;
  localparam logic [7:0] HF_CTRL_OFFSET    = 8'h04;
  localparam logic [7:0] CLK_STATUS_OFFSET = 8'h08;
  localparam logic [7:0] INT_STATUS_OFFSET = 8'h0c;
  localparam logic [7:0] INT_MASK_OFFSET   = 8'h10;

  // main_clock_config_reg fields
  localparam int          DEAD_CHECK_BIT    = 0;
  localparam int          WINDOW_LSB        = 4;
  localparam int          WINDOW_W          = 4;
  localparam logic [3:0]  WINDOW_MIN        = 4'h1;
  localparam logic [3:0]  WINDOW_MAX        = 4'hc;
  localparam logic [3:0]  WINDOW_RESET      = 4'hc;

  // hf control fields
  localparam int          HF_START_BIT      = 0;
  localparam int          HF_SRC_BIT        = 1;

  // clock_status_reg fields
  localparam int          GOOD_BIT          = 0;
  localparam int          DEAD_BIT          = 1;
  localparam int          MON_ACTIVE_BIT    = 2;
  localparam int          SETTLING_BIT      = 3;

  // interrupt status / mask fields
  localparam int          IRQ_W             = 3;
  localparam int          IRQ_GOOD_BIT      = 0;
  localparam int          IRQ_DEAD_BIT      = 1;
  localparam int          IRQ_FAULT_BIT     = 2;

  // timing
  localparam int          CLK_PERIOD_NS     = 50;
  localparam int          HF_SETTLE_NS      = 500000;
  localparam int          HF_SETTLE_CYCLES  = (HF_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          SETTLE_W          = 20;
  localparam int          HF_MIN_EDGES      = 4;
  localparam int          EDGE_CNT_W        = 3;
  localparam int          BOOT_RESET_NS     = 800;
  localparam int          BOOT_RESET_CYCLES = (BOOT_RESET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          BOOT_CNT_W        = 5;

  typedef enum logic [1:0] {
    HF_IDLE   = 2'b00,
    HF_SETTLE = 2'b01,
    HF_GOOD   = 2'b10,
    HF_DEAD   = 2'b11
  } hf_state_e;

endpackage

// ===== activity_edge.sv
`timescale 1ns/10ps
module activity_edge (
  // clock and reset
  input  wire logic core_clk,
  input  wire logic rstn,
  // sampled signal and its rising edge
  input  wire logic sig,
  output logic      rise
);

  logic last;

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      last <= 1'b0;
    end else begin
      last <= sig;
    end
  end

  assign rise = sig & ~last;

endmodule

// ===== settle_timer.sv
`timescale 1ns/10ps
module settle_timer #(
  parameter int WIDTH = 20,
  parameter int COUNT = 10000
) (
  // clock and reset
  input  wire logic core_clk,
  input  wire logic rstn,
  // control
  input  wire logic start,
  output logic      busy,
  output logic      done
);

  logic [WIDTH-1:0] count;

  // a start while busy restarts the interval
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      count <= '0;
      busy  <= 1'b0;
      done  <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start) begin
        count <= WIDTH'(COUNT - 1);
        busy  <= 1'b1;
      end else if (busy) begin
        if (count == '0) begin
          busy <= 1'b0;
          done <= 1'b1;
        end else begin
          count <= count - 1'b1;
        end
      end
    end
  end

endmodule

// ===== clock_fault_monitors_props.sv
`timescale 1ns/10ps
module clock_fault_monitors_props
  import clock_fault_monitors_pkg::*;
(
  // clock and reset
  input wire logic        core_clk,
  input wire logic        rstn,
  // apb
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic [31:0] prdata,
  input wire logic        pslverr,
  // modes and outputs
  input wire logic        deep_standby_mode,
  input wire logic        shutdownMode,
  input wire logic        boot_reset,
  input wire logic        hfClockSelectOk
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);
  logic done;
  logic rdStat;
  logic hfStart;
  logic suspended;
  logic cfgWritten;
  assign done = psel && penable && pready;
  assign rdStat = done && !pwrite && !pslverr && paddr == CLK_STATUS_OFFSET;
  assign hfStart = done && pwrite && paddr == HF_CTRL_OFFSET && pwdata[HF_START_BIT] && !pwdata[HF_SRC_BIT];
  assign suspended = deep_standby_mode || shutdownMode;
  // a fault before any config write means the monitor woke up enabled
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn)
      cfgWritten <= 1'b0;
    else if (done && pwrite && paddr == MAIN_CFG_OFFSET)
      cfgWritten <= 1'b1;
  end
  sequence s_access;
    psel && !penable ##1 psel && penable;
  endsequence
  sequence s_bootPulse;
    boot_reset [*8] ##1 boot_reset [*8] ##1 !boot_reset;
  endsequence
  a_apb_wait: assert property (s_access |=> pready) else $error("no ready in second access cycle");
  a_err_data: assert property (pslverr |-> pready && prdata == 32'h0) else $error("error response carries data");
  a_boot_len: assert property ($rose(boot_reset) |-> s_bootPulse) else $error("boot reset length");
  a_reset_off: assert property (!cfgWritten |-> !boot_reset) else $error("fault while unconfigured");
  a_hf_clear: assert property (hfStart |-> ##2 !hfClockSelectOk [*8]) else $error("good kept on start");
  a_flag_once: assert property (rdStat |-> !(prdata[GOOD_BIT] && prdata[DEAD_BIT])) else $error("both flags");
  a_dead_nosel: assert property (rdStat && prdata[DEAD_BIT] |-> !hfClockSelectOk) else $error("dead but ok");
  a_susp_flag: assert property (suspended [*3] ##0 rdStat |-> !prdata[MON_ACTIVE_BIT]) else $error("active");
  a_susp_quiet: assert property (suspended [*8] |-> !$rose(boot_reset)) else $error("fault while suspended");
endmodule
bind clock_fault_monitors clock_fault_monitors_props u_props (
  .core_clk(core_clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .pready(pready), .prdata(prdata), .pslverr(pslverr), .deep_standby_mode(deep_standby_mode),
  .shutdownMode(shutdownMode), .boot_reset(boot_reset), .hfClockSelectOk(hfClockSelectOk));

// ===== clock_fault_monitors_test.sv
`timescale 1ns/10ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin miscompares++; $display("wrong value %0t %h %h", $time, g, e); end end
module clock_fault_monitors_test
  import clock_fault_monitors_pkg::*;
;
  localparam int SETTLE = 20;
  logic        core_clk, rstn, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rdata;
  logic        low_freq_clock, mainClockActivity, hf_crystal_osc, hf_clock_input_pin;
  logic        deep_standby_mode, shutdownMode, boot_reset, hfClockSelectOk, hfCrystalEnable, hfSourceSelect, irq;
  logic        mainRun, oscRun, pinRun;
  logic [1:0]  lfCnt;
  int          compares, miscompares, cycles;

  clock_fault_monitors #(.SETTLE_CYCLES(SETTLE)) DUT (
    .core_clk(core_clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr), .low_freq_clock(low_freq_clock),
    .mainClockActivity(mainClockActivity), .hf_crystal_osc(hf_crystal_osc), .hf_clock_input_pin(hf_clock_input_pin),
    .deep_standby_mode(deep_standby_mode), .shutdownMode(shutdownMode), .boot_reset(boot_reset),
    .hfClockSelectOk(hfClockSelectOk), .hfCrystalEnable(hfCrystalEnable), .hfSourceSelect(hfSourceSelect), .irq(irq));

  always #25 core_clk = ~core_clk;

  // slow reference at one eighth of core_clk; stopped sources hold their level, i.e. stuck
  always @(posedge core_clk) begin
    lfCnt <= lfCnt + 2'd1;
    if (lfCnt == 2'd3)
      low_freq_clock <= ~low_freq_clock;
    if (mainRun)
      mainClockActivity <= ~mainClockActivity;
    if (oscRun)
      hf_crystal_osc <= ~hf_crystal_osc;
    if (pinRun)
      hf_clock_input_pin <= ~hf_clock_input_pin;
    cycles <= cycles + 1;
    if (cycles == 4000) begin
      miscompares++;
      conclude();
    end
  end

  task automatic conclude;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    // no assumed latency: only the bench timeout ends this wait
    do begin
      @(posedge core_clk);
    end while (pready !== 1'b1);
    rdata = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    `CHK(rdata & m, e)
  endtask

  task automatic t_reset;
    rd(MAIN_CFG_OFFSET, 32'hffffffff, 32'h000000c0);
    rd(CLK_STATUS_OFFSET, 32'hffffffff, 32'h00000000);
    rd(INT_MASK_OFFSET, 32'hffffffff, 32'h00000000);
    apb(1'b0, 8'h14, 32'h0);
    `CHK({err, rdata}, 33'h100000000)
    tick(60);
    `CHK(boot_reset, 1'b0)
  endtask

  task automatic t_hf;
    oscRun <= 1'b1;
    apb(1'b1, HF_CTRL_OFFSET, 32'h1);
    rd(CLK_STATUS_OFFSET, 32'hb, 32'h8);
    `CHK(hfCrystalEnable, 1'b1)
    tick(SETTLE + 4);
    rd(CLK_STATUS_OFFSET, 32'hb, 32'h1);
    `CHK({hfClockSelectOk, irq}, 2'b10)
    apb(1'b1, INT_MASK_OFFSET, 32'h7);
    tick(1);
    `CHK(irq, 1'b1)
    rd(INT_STATUS_OFFSET, 32'h3, 32'h1);
    tick(1);
    `CHK(irq, 1'b0)
    oscRun <= 1'b0;
    apb(1'b1, HF_CTRL_OFFSET, 32'h1);
    tick(1);
    `CHK(hfClockSelectOk, 1'b0)
    tick(SETTLE + 4);
    apb(1'b1, CLK_STATUS_OFFSET, 32'h0);
    rd(CLK_STATUS_OFFSET, 32'hb, 32'h2);
    rd(INT_STATUS_OFFSET, 32'h3, 32'h2);
    pinRun <= 1'b1;
    apb(1'b1, HF_CTRL_OFFSET, 32'h2);
    rd(CLK_STATUS_OFFSET, 32'hb, 32'h8);
    tick(SETTLE + 4);
    rd(CLK_STATUS_OFFSET, 32'hb, 32'h1);
    `CHK(hfSourceSelect, 1'b1)
    pinRun <= 1'b0;
    apb(1'b1, HF_CTRL_OFFSET, 32'h0);
    apb(1'b1, HF_CTRL_OFFSET, 32'h2);
    tick(SETTLE + 4);
    rd(CLK_STATUS_OFFSET, 32'hb, 32'h2);
    rd(INT_STATUS_OFFSET, 32'h3, 32'h3);
  endtask

  task automatic t_main;
    int n;
    mainRun <= 1'b1;
    apb(1'b1, MAIN_CFG_OFFSET, 32'h00000000);
    rd(MAIN_CFG_OFFSET, 32'hffffffff, 32'h00000010);
    apb(1'b1, MAIN_CFG_OFFSET, 32'h000000f0);
    rd(MAIN_CFG_OFFSET, 32'hffffffff, 32'h000000c0);
    apb(1'b1, MAIN_CFG_OFFSET, 32'h00000031); // slow clock already running
    rd(CLK_STATUS_OFFSET, 32'h4, 32'h4);
    tick(80);
    rd(INT_STATUS_OFFSET, 32'h4, 32'h0);
    mainRun <= 1'b0;
    n = 0;
    while (boot_reset !== 1'b1 && n < 40) begin
      tick(1);
      n++;
    end
    // window of 3 slow edges at 8 cycles each, plus sampling lag
    `CHK(n >= 14 && n <= 32, 1'b1)
    n = 0;
    while (boot_reset === 1'b1 && n < 40) begin
      tick(1);
      n++;
    end
    `CHK(n, 16)
    mainRun <= 1'b1;
    rd(INT_STATUS_OFFSET, 32'h4, 32'h4);
    mainRun <= 1'b0;
    for (int i = 0; i < 2; i++) begin
      {deep_standby_mode, shutdownMode} <= i ? 2'b10 : 2'b01;
      tick(60);
      rd(INT_STATUS_OFFSET, 32'h4, 32'h0);
      rd(CLK_STATUS_OFFSET, 32'h4, 32'h0);
    end
    {deep_standby_mode, shutdownMode} <= 2'b00;
    rd(CLK_STATUS_OFFSET, 32'h4, 32'h4);
    tick(40);
    rd(INT_STATUS_OFFSET, 32'h4, 32'h4);
    mainRun <= 1'b1;
    apb(1'b1, MAIN_CFG_OFFSET, 32'h00000030);
    // disabled monitor must stay quiet with the main clock stopped
    mainRun <= 1'b0;
    apb(1'b0, INT_STATUS_OFFSET, 32'h0);
    tick(40);
    rd(INT_STATUS_OFFSET, 32'h4, 32'h0);
    `CHK(boot_reset, 1'b0)
  endtask

  initial begin
    {core_clk, rstn, psel, penable, pwrite, paddr, pwdata} = '0;
    {low_freq_clock, mainClockActivity, hf_crystal_osc, hf_clock_input_pin} = '0;
    {deep_standby_mode, shutdownMode, mainRun, oscRun, pinRun, lfCnt} = '0;
    compares = 0;
    miscompares = 0;
    cycles = 0;
    tick(3);
    rstn <= 1'b1;
    tick(1);
    t_reset();
    t_hf();
    t_main();
    conclude();
  end
endmodule
